// >>> rtl/slir_core.v
// slir_core.v: per-sector volatile lock bits and identification readout,
// reached over a single-line serial link (mode 0, command byte first).
// assumes link pins come from outside the clock domain and are oversampled
// Overview of operation
// - one volatile lock register per sector
// - lock write executes only while lock-down clear
// - lock read returns current sector register
// - lock-down bit zero after power-up
// - lock-down set blocks changes until reset
// - write-lock bit zero after power-up
// - write-lock set blocks program and erase
// - reset clears every write-lock bit
// - all three identity reads return same bytes
// - maker, memory type, capacity bytes first
// - byte 4 is remaining count 10h
// - byte 5 is extended identification byte
// - byte 6 is configuration, 00h standard
// - bytes 7 to 20 unique identifier
// - 64 register bytes, then 00h, no wrap
// - discovery read returns internal parameter table
`timescale 1ns/1ns
`default_nettype none
`include "slir_defs.vh"

module slir_core #(
    parameter [7:0]   MAKER_CODE    = 8'h5C,   // arbitrary value
    parameter [7:0]   MEMORY_TYPE   = 8'hA4,   // arbitrary value
    parameter [7:0]   CAPACITY_CODE = 8'h3E,   // arbitrary value
    parameter [111:0] UNIQUE_ID     = 112'h0123456789ABCDEF0123456789AB, // arbitrary value
    parameter         EXT_GEN       = 1'b1,
    parameter         EXT_BPS       = 1'b0,
    parameter         EXT_HOLD_RST  = 1'b0,
    parameter         EXT_HW_RESET  = 1'b0,
    parameter [127:0] DISC_TABLE    = 128'h0   // arbitrary value
) (
    // clock and reset
    input  wire         clock,
    input  wire         resetn,
    // serial link
    input  wire         linkClk,
    input  wire         linkSelN,
    input  wire         linkDataIn,
    output wire         linkDataOut,
    output wire         linkDataOeN,
    // program and erase permission query
    input  wire [10:0]  peSector,
    output wire         peAllowed,
    // general purpose read register contents, byte 0 in the top bits
    input  wire [511:0] gprContents
);

    // pin synchronisers: 0 clock, 1 select, 2 data in
    reg  [2:0] pinS1_reg;
    reg  [2:0] pinS2_reg;
    reg  [2:0] pinS3_reg;
    reg  [2:0] pinLvl_reg;
    wire [2:0] pinAgree;
    wire       clkRise;
    wire       clkFall;
    wire       selActive;

    // frame state
    reg  [2:0]  rxBit_reg;
    reg  [7:0]  rxShift_reg;
    reg  [7:0]  byteIdx_reg;
    reg  [7:0]  opcode_reg;
    reg  [31:0] addr_reg;
    reg         txActive_reg;
    reg         genActive_reg;
    reg  [7:0]  outIdx_reg;
    reg  [2:0]  txBit_reg;
    reg  [6:0]  txShift_reg;
    reg         dataOut_reg;
    reg         dataOeN_reg;
    reg         peAllowed_reg;
    wire [7:0]  rxByteNow;
    wire        byteDone;
    reg         startOut;
    reg  [7:0]  genByte;
    // discovery table position wraps every table length
    wire [`SLIR_DISC_AW-1:0] discIdx;

    // sector lock registers
    reg  [`SLIR_LOCK_W-1:0] lockMem [0:`SLIR_SECTORS-1];
    wire [`SLIR_SECT_W-1:0] lockSector;
    wire [`SLIR_LOCK_W-1:0] lockCur;
    wire                    lockWrite;
    integer                 i;
    integer                 j;

    // fifo wiring
    wire       fifoInReady;
    wire       fifoOutValid;
    wire       fifoOutReady;
    wire [7:0] fifoOutData;
    wire       fifoPush;

    // level counts once second and third stages agree
    always @(posedge clock) begin
        if (!resetn) begin
            pinS1_reg  <= 3'h2;
            pinS2_reg  <= 3'h2;
            pinS3_reg  <= 3'h2;
            pinLvl_reg <= 3'h2;
        end else begin
            pinS1_reg <= {linkDataIn, linkSelN, linkClk};
            pinS2_reg <= pinS1_reg;
            pinS3_reg <= pinS2_reg;
            for (i = 0; i < 3; i = i + 1) begin
                if (pinAgree[i]) begin
                    pinLvl_reg[i] <= pinS2_reg[i];
                end
            end
        end
    end

    assign pinAgree  = ~(pinS2_reg ^ pinS3_reg);
    assign clkRise   = selActive && pinAgree[0] && pinS2_reg[0] && !pinLvl_reg[0];
    assign clkFall   = selActive && pinAgree[0] && !pinS2_reg[0] && pinLvl_reg[0];
    assign selActive = !pinLvl_reg[1];
    assign rxByteNow = {rxShift_reg[6:0], pinLvl_reg[2]};
    assign byteDone  = clkRise && (rxBit_reg == 3'h7);

    // decide where the answer of each command starts
    always @* begin
        startOut = 1'b0;
        if (byteDone) begin
            if (byteIdx_reg == `SLIR_IDX_ID_START) begin
                startOut = (rxByteNow == `SLIR_OP_ID_SINGLE) || (rxByteNow == `SLIR_OP_ID_ALT) ||
                           (rxByteNow == `SLIR_OP_ID_MULTI);
            end else begin
                case (opcode_reg)
                    `SLIR_OP_RD_LOCK:   startOut = (byteIdx_reg == `SLIR_IDX_LOCK_START);
                    `SLIR_OP_DISCOVERY: startOut = (byteIdx_reg == `SLIR_IDX_DISC_START);
                    `SLIR_OP_RD_GPR:    startOut = (byteIdx_reg == `SLIR_IDX_GPR_START);
                    default:            startOut = 1'b0;
                endcase
            end
        end
    end

    // command, address and frame tracking
    always @(posedge clock) begin
        if (!resetn || !selActive) begin
            rxBit_reg     <= 3'h0;
            rxShift_reg   <= 8'h00;
            byteIdx_reg   <= `SLIR_IDX_CMD;
            opcode_reg    <= 8'h00;
            addr_reg      <= 32'h0000_0000;
            txActive_reg  <= 1'b0;
            genActive_reg <= 1'b0;
        end else begin
            if (clkRise) begin
                rxBit_reg   <= rxBit_reg + 3'h1;
                rxShift_reg <= rxByteNow;
            end
            if (byteDone) begin
                if (byteIdx_reg == `SLIR_IDX_CMD) begin
                    opcode_reg <= rxByteNow;
                end else if (byteIdx_reg <= `SLIR_IDX_ADDR_LAST) begin
                    addr_reg <= {addr_reg[23:0], rxByteNow};
                end
                if (byteIdx_reg != `SLIR_IDX_MAX) begin
                    byteIdx_reg <= byteIdx_reg + 8'h01;
                end
            end
            if (startOut) begin
                txActive_reg  <= 1'b1;
                genActive_reg <= 1'b1;
            end
        end
    end

    // lock registers: the sector comes from the address bytes
    assign lockSector = addr_reg[`SLIR_SECT_LSB +: `SLIR_SECT_W];
    assign lockCur    = lockMem[lockSector];
    assign lockWrite  = byteDone && (opcode_reg == `SLIR_OP_WR_LOCK) &&
                        (byteIdx_reg == `SLIR_IDX_LOCK_DATA);

    always @(posedge clock) begin
        if (!resetn) begin
            for (j = 0; j < `SLIR_SECTORS; j = j + 1) begin
                lockMem[j] <= `SLIR_LOCK_CLEAR;
            end
        end else if (lockWrite && !lockCur[`SLIR_LOCKDOWN_BIT]) begin
            lockMem[lockSector] <= rxByteNow[`SLIR_LOCK_W-1:0];
        end
    end

    // program and erase permission for the queried sector
    always @(posedge clock) begin
        if (!resetn) begin
            peAllowed_reg <= 1'b1;
        end else begin
            peAllowed_reg <= !lockMem[peSector][`SLIR_WRLOCK_BIT];
        end
    end

    assign peAllowed = peAllowed_reg;

    // identification stream byte at a given position
    function [7:0] idByte;
        input [7:0] pos;
        integer     p;
        begin
            p = pos;
            if (p == `SLIR_ID_POS_MAKER) begin
                idByte = MAKER_CODE;
            end else if (p == `SLIR_ID_POS_TYPE) begin
                idByte = MEMORY_TYPE;
            end else if (p == `SLIR_ID_POS_CAP) begin
                idByte = CAPACITY_CODE;
            end else if (p == `SLIR_ID_POS_REMAIN) begin
                idByte = `SLIR_ID_REMAINING;
            end else if (p == `SLIR_ID_POS_EXT) begin
                idByte = 8'h00;
                idByte[`SLIR_EXT_GEN_BIT]   = EXT_GEN;
                idByte[`SLIR_EXT_BPS_BIT]   = EXT_BPS;
                idByte[`SLIR_EXT_HOLD_BIT]  = EXT_HOLD_RST;
                idByte[`SLIR_EXT_HWRST_BIT] = EXT_HW_RESET;
            end else if (p == `SLIR_ID_POS_CONFIG) begin
                idByte = `SLIR_ID_CONFIG_STD;
            end else if (p <= `SLIR_ID_POS_LAST) begin
                idByte = UNIQUE_ID[8*(`SLIR_ID_POS_LAST-p) +: 8];
            end else begin
                idByte = `SLIR_FILL_BYTE;
            end
        end
    endfunction

    assign discIdx = addr_reg[`SLIR_DISC_AW-1:0] + outIdx_reg[`SLIR_DISC_AW-1:0];

    // next byte of the answer
    always @* begin
        case (opcode_reg)
            `SLIR_OP_RD_LOCK: begin
                genByte = {`SLIR_LOCK_PAD, lockCur};
            end
            `SLIR_OP_DISCOVERY: begin
                genByte = DISC_TABLE[8*(`SLIR_DISC_LAST - discIdx) +: 8];
            end
            `SLIR_OP_RD_GPR: begin
                if (outIdx_reg < `SLIR_GPR_BYTES) begin
                    genByte = gprContents[8*(`SLIR_GPR_LAST - outIdx_reg) +: 8];
                end else begin
                    genByte = `SLIR_FILL_BYTE;
                end
            end
            `SLIR_OP_ID_SINGLE, `SLIR_OP_ID_ALT, `SLIR_OP_ID_MULTI: begin
                genByte = idByte(outIdx_reg);
            end
            default: begin
                genByte = `SLIR_FILL_BYTE;
            end
        endcase
    end

    // producer: fills the buffer ahead of the serial shifter
    assign fifoPush = genActive_reg && selActive;

    always @(posedge clock) begin
        if (!resetn || !selActive) begin
            outIdx_reg <= 8'h00;
        end else if (fifoPush && fifoInReady && (outIdx_reg != `SLIR_IDX_MAX)) begin
            outIdx_reg <= outIdx_reg + 8'h01;
        end
    end

    slir_fifo #(
        .WIDTH (`SLIR_FIFO_WIDTH),
        .DEPTH (`SLIR_FIFO_DEPTH),
        .AW    (`SLIR_FIFO_AW)
    ) outBuf (
        .clock    (clock),
        .resetn   (resetn),
        .clear    (!selActive),
        .inValid  (fifoPush),
        .inReady  (fifoInReady),
        .inData   (genByte),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    // shifter: a byte leaves the buffer at its first falling edge
    assign fifoOutReady = clkFall && txActive_reg && (txBit_reg == 3'h0);

    always @(posedge clock) begin
        if (!resetn || !selActive) begin
            txBit_reg   <= 3'h0;
            txShift_reg <= 7'h00;
            dataOut_reg <= 1'b0;
            dataOeN_reg <= 1'b1;
        end else begin
            dataOeN_reg <= !txActive_reg;
            if (clkFall && txActive_reg) begin
                txBit_reg <= txBit_reg + 3'h1;
                if (txBit_reg == 3'h0) begin
                    dataOut_reg <= fifoOutValid ? fifoOutData[7] : 1'b0;
                    txShift_reg <= fifoOutValid ? fifoOutData[6:0] : 7'h00;
                end else begin
                    dataOut_reg <= txShift_reg[6];
                    txShift_reg <= {txShift_reg[5:0], 1'b0};
                end
            end
        end
    end

    assign linkDataOut = dataOut_reg;
    assign linkDataOeN = dataOeN_reg;

endmodule // slir_core

`default_nettype wire

// >>> rtl/slir_defs.vh
// slir_defs.vh: constants of the sector lock and identification readout block
// assumes inclusion by the block's design files only; definitions only
`ifndef SLIR_DEFS_VH
`define SLIR_DEFS_VH

// command codes
`define SLIR_OP_ID_SINGLE   8'h9F
`define SLIR_OP_ID_ALT      8'h9E
`define SLIR_OP_ID_MULTI    8'hAF
`define SLIR_OP_DISCOVERY   8'h5A
`define SLIR_OP_WR_LOCK     8'hE1
`define SLIR_OP_RD_LOCK     8'hE8
`define SLIR_OP_RD_GPR      8'h96

// frame byte positions (byte 0 is the command)
`define SLIR_IDX_CMD        8'h00
`define SLIR_IDX_ADDR_LAST  8'h04
`define SLIR_IDX_LOCK_DATA  8'h05
`define SLIR_IDX_ID_START   8'h00
`define SLIR_IDX_GPR_START  8'h01
`define SLIR_IDX_DISC_START 8'h04
`define SLIR_IDX_LOCK_START 8'h04
`define SLIR_IDX_MAX        8'hFF

// sector lock layout
`define SLIR_SECTORS        2048
`define SLIR_SECT_W         11
`define SLIR_SECT_LSB       16
`define SLIR_LOCK_W         2
`define SLIR_LOCK_CLEAR     2'h0
`define SLIR_LOCKDOWN_BIT   1
`define SLIR_WRLOCK_BIT     0
`define SLIR_LOCK_PAD       6'h00

// identification stream
`define SLIR_ID_REMAINING   8'h10
`define SLIR_ID_CONFIG_STD  8'h00
`define SLIR_ID_POS_MAKER   0
`define SLIR_ID_POS_TYPE    1
`define SLIR_ID_POS_CAP     2
`define SLIR_ID_POS_REMAIN  3
`define SLIR_ID_POS_EXT     4
`define SLIR_ID_POS_CONFIG  5
`define SLIR_ID_POS_UID     6
`define SLIR_ID_POS_LAST    19
`define SLIR_EXT_GEN_BIT    6
`define SLIR_EXT_BPS_BIT    5
`define SLIR_EXT_HOLD_BIT   3
`define SLIR_EXT_HWRST_BIT  2

// general purpose read register and discovery table
`define SLIR_GPR_BYTES      64
`define SLIR_GPR_LAST       63
`define SLIR_FILL_BYTE      8'h00
`define SLIR_DISC_BYTES     16
`define SLIR_DISC_LAST      15
`define SLIR_DISC_AW        4

// output buffer
`define SLIR_FIFO_WIDTH     8
`define SLIR_FIFO_DEPTH     16
`define SLIR_FIFO_AW        4

`endif

// >>> rtl/slir_fifo.v
// slir_fifo.v: synchronous FIFO with valid/ready on both sides and a clear
// assumes one clock; clear empties the buffer at once
`timescale 1ns/1ns
`default_nettype none

module slir_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire             clock,
    input  wire             resetn,
    input  wire             clear,
    // filling side
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    // draining side
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_reg;
    reg [AW-1:0]    rdPtr_reg;
    reg [AW:0]      count_reg;
    wire            doPush;
    wire            doPop;

    assign inReady  = (count_reg != DEPTH[AW:0]);
    assign outValid = (count_reg != {(AW+1){1'b0}});
    assign outData  = mem[rdPtr_reg];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    always @(posedge clock) begin
        if (doPush) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always @(posedge clock) begin
        if (!resetn || clear) begin
            wrPtr_reg <= {AW{1'b0}};
            rdPtr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (doPush) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doPop) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            if (doPush && !doPop) begin
                count_reg <= count_reg + 1'b1;
            end else if (doPop && !doPush) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule // slir_fifo

`default_nettype wire

// >>> bench/slir_core_sva.sv
// slir_core_sva.sv: port-level assertions for the sector lock and id readout core
// assumes the bench link timing: half link period of 4 clocks
`timescale 1ns/1ns
`default_nettype none

module slir_core_sva (
    // clock and reset
    input wire logic        clock,
    input wire logic        resetn,
    // serial link
    input wire logic        linkClk,
    input wire logic        linkSelN,
    input wire logic        linkDataOut,
    input wire logic        linkDataOeN,
    // permission query
    input wire logic [10:0] peSector,
    input wire logic        peAllowed
);
    logic       lockSeen_reg;
    logic       prevClk_reg;
    logic [4:0] selHighCnt_reg;
    logic [3:0] fallCnt_reg;

    // frame history and cycles since the last link clock fall
    always @(posedge clock) begin
        prevClk_reg <= linkClk;
        fallCnt_reg <= (prevClk_reg && !linkClk) ? 4'h1 : fallCnt_reg + {3'h0, fallCnt_reg != 4'hF};
        if (!resetn) begin
            lockSeen_reg   <= 1'b0;
            selHighCnt_reg <= 5'h1F;
        end else begin
            lockSeen_reg   <= lockSeen_reg | !linkSelN;
            selHighCnt_reg <= !linkSelN ? 5'h00 : selHighCnt_reg + {4'h0, selHighCnt_reg != 5'h1F};
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_released;
        $rose(resetn);
    endsequence
    sequence s_frameStart;
        linkSelN ##1 !linkSelN;
    endsequence

    AST_RST_PE: assert property (s_released |-> peAllowed)
        else $error("permission not granted after reset");
    AST_RST_LINK: assert property (s_released |-> linkDataOeN && !linkDataOut)
        else $error("link driven after reset");
    AST_FRESH_PE: assert property (!lockSeen_reg |-> peAllowed)
        else $error("sector protected before any lock frame");
    AST_PE_FRAME: assert property ($past(peSector) == $past(peSector, 2) && $changed(peAllowed)
        |-> selHighCnt_reg < 5'h14)
        else $error("permission changed outside a frame");
    AST_IDLE_QUIET: assert property (linkSelN [*8] |-> linkDataOeN)
        else $error("data driven while not selected");
    AST_CMD_QUIET: assert property (s_frameStart |=> linkDataOeN [*8])
        else $error("data driven during command byte");
    AST_RELEASE: assert property ($rose(linkSelN) |-> ##[1:8] linkDataOeN)
        else $error("data line not released after frame");
    AST_BIT_TIMING: assert property (!linkSelN && !linkDataOeN && $changed(linkDataOut)
        |-> fallCnt_reg inside {[4'h3:4'h6]})
        else $error("output bit changed away from a falling link edge");
endmodule // slir_core_sva

bind slir_core slir_core_sva i_sva (
    .clock       (clock),
    .resetn      (resetn),
    .linkClk     (linkClk),
    .linkSelN    (linkSelN),
    .linkDataOut (linkDataOut),
    .linkDataOeN (linkDataOeN),
    .peSector    (peSector),
    .peAllowed   (peAllowed)
);

`default_nettype wire

// >>> bench/slir_host_model.sv
// slir_host_model.sv: serial host issuing whole frames, mode 0, MSB first
// assumes the caller fills txBuf and reads rxBuf; link clock idles low
`timescale 1ns/1ns
`default_nettype none

module slir_host_model (
    // clock
    input  wire logic clock,
    // serial link
    output var logic  linkClk,
    output var logic  linkSelN,
    output var logic  linkDataIn,
    input  wire logic linkDataOut,
    input  wire logic linkDataOeN
);
    logic [7:0] txBuf [0:79];
    logic [7:0] rxBuf [0:79];

    initial begin
        linkClk    = 1'b0;
        linkSelN   = 1'b1;
        linkDataIn = 1'b0;
        for (int i = 0; i < 80; i++) txBuf[i] = 8'h00;
    end

    // sampling just before each fall sees the bit launched one fall earlier
    task automatic xfer(input int nBytes);
        @(posedge clock);
        linkSelN <= 1'b0;
        repeat (4) @(posedge clock);
        for (int i = 0; i < nBytes * 8; i++) begin
            linkDataIn <= txBuf[i / 8][7 - i % 8];
            repeat (4) @(posedge clock);
            linkClk <= 1'b1;
            repeat (4) @(posedge clock);
            rxBuf[i / 8][7 - i % 8] = linkDataOut;
            linkClk <= 1'b0;
        end
        repeat (4) @(posedge clock);
        linkSelN   <= 1'b1;
        linkDataIn <= ~linkDataIn;
        repeat (8) @(posedge clock);
    endtask
endmodule // slir_host_model

`default_nettype wire

// >>> bench/slir_tb.sv
// slir_tb.sv: self-checking bench for the sector lock and id readout core
// assumes a 25 MHz clock and a 320 ns link period made by the host model
`timescale 1ns/1ns
`default_nettype none

module tb;
    localparam [7:0]   MAKER = 8'h5C; // arbitrary value
    localparam [7:0]   MTYPE = 8'hA4; // arbitrary value
    localparam [7:0]   CAPAC = 8'h3E; // arbitrary value
    localparam [111:0] FACTORY_UNIQUE_IDENTIFIER   = 112'hF0E1D2C3B4A5968778695A4B3C2D; // arbitrary value
    localparam [127:0] DISC  = 128'h112233445566778899AABBCCDDEEFF10;

    logic         clock;
    logic         resetn;
    wire          linkClk;
    wire          linkSelN;
    wire          linkDataIn;
    wire          linkDataOut;
    wire          linkDataOeN;
    logic [10:0]  peSector;
    wire          peAllowed;
    logic [511:0] gprContents;
    int           badCount;
    int           nCompared;

    slir_core #(.MAKER_CODE(MAKER), .MEMORY_TYPE(MTYPE), .CAPACITY_CODE(CAPAC), .UNIQUE_ID(FACTORY_UNIQUE_IDENTIFIER),
        .EXT_BPS(1'b1), .EXT_HW_RESET(1'b1), .DISC_TABLE(DISC)) i_dut (
        .clock(clock), .resetn(resetn), .linkClk(linkClk), .linkSelN(linkSelN), .linkDataIn(linkDataIn),
        .linkDataOut(linkDataOut), .linkDataOeN(linkDataOeN), .peSector(peSector), .peAllowed(peAllowed),
        .gprContents(gprContents));

    slir_host_model i_host (.clock(clock), .linkClk(linkClk), .linkSelN(linkSelN), .linkDataIn(linkDataIn),
        .linkDataOut(linkDataOut), .linkDataOeN(linkDataOeN));

    always #20 clock = ~clock;

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic doReset;
        @(posedge clock);
        resetn <= 1'b0;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
    endtask

    task automatic peChk(input logic [10:0] sec, input logic exp);
        @(posedge clock);
        peSector <= sec;
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk("peAllowed", {7'h00, exp}, {7'h00, peAllowed});
    endtask

    task automatic lockCmd(input logic [7:0] op, input logic [10:0] sec, input logic [7:0] d, input int n);
        i_host.txBuf[0] = op;
        i_host.txBuf[1] = {5'h00, sec[10:8]};
        i_host.txBuf[2] = sec[7:0];
        i_host.txBuf[3] = 8'h00;
        i_host.txBuf[4] = 8'h00;
        i_host.txBuf[5] = d;
        i_host.xfer(n);
    endtask

    task automatic lockWr(input logic [10:0] sec, input logic [7:0] d);
        lockCmd(8'hE1, sec, d, 6);
    endtask

    task automatic lockRd(input logic [10:0] sec, input logic [7:0] exp);
        lockCmd(8'hE8, sec, 8'h00, 7);
        chk("lockRead", exp, i_host.rxBuf[5]);
        chk("lockReadAgain", exp, i_host.rxBuf[6]);
    endtask

    task automatic idRead(input logic [7:0] op);
        i_host.txBuf[0] = op;
        i_host.xfer(23);
        chk("idMaker", MAKER, i_host.rxBuf[1]);
        chk("idType", MTYPE, i_host.rxBuf[2]);
        chk("idCapacity", CAPAC, i_host.rxBuf[3]);
        chk("idRemaining", 8'h10, i_host.rxBuf[4]);
        chk("idExtended", 8'h64, i_host.rxBuf[5]);
        chk("idConfig", 8'h00, i_host.rxBuf[6]);
        for (int k = 0; k < 14; k++) chk("idUnique", FACTORY_UNIQUE_IDENTIFIER[111 - 8 * k -: 8], i_host.rxBuf[7 + k]);
    endtask

    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clock);
        badCount++;
        $display("Error runTime expected finished seen timeout");
        report_and_stop();
    end

    initial begin
        clock     = 1'b0;
        resetn    = 1'b0;
        peSector  = 11'h000;
        badCount  = 0;
        nCompared = 0;
        for (int k = 0; k < 64; k++) gprContents[511 - 8 * k -: 8] = 8'(k * 7 + 3);
        doReset();
        peChk(11'h005, 1'b1);
        idRead(8'h9F);
        idRead(8'h9E);
        idRead(8'hAF);
        lockRd(11'h005, 8'h00);
        lockWr(11'h005, 8'hFD);
        lockRd(11'h005, 8'h01);
        peChk(11'h005, 1'b0);
        peChk(11'h006, 1'b1);
        lockRd(11'h7FF, 8'h00);
        lockWr(11'h005, 8'h02);
        lockRd(11'h005, 8'h02);
        peChk(11'h005, 1'b1);
        lockWr(11'h005, 8'h01);
        lockRd(11'h005, 8'h02);
        lockWr(11'h7FF, 8'h03);
        lockWr(11'h7FF, 8'h00);
        lockRd(11'h7FF, 8'h03);
        peChk(11'h7FF, 1'b0);
        doReset();
        lockRd(11'h005, 8'h00);
        peChk(11'h7FF, 1'b1);
        lockWr(11'h7FF, 8'h01);
        lockRd(11'h7FF, 8'h01);
        i_host.txBuf[0] = 8'h96;
        i_host.xfer(68);
        for (int k = 0; k < 64; k++) chk("gprByte", gprContents[511 - 8 * k -: 8], i_host.rxBuf[2 + k]);
        chk("gprFill", 8'h00, i_host.rxBuf[66]);
        chk("gprFillNext", 8'h00, i_host.rxBuf[67]);
        i_host.txBuf[0] = 8'h5A;
        i_host.txBuf[1] = 8'h00;
        i_host.txBuf[2] = 8'h00;
        i_host.txBuf[3] = 8'h0E;
        i_host.txBuf[4] = 8'h0E;
        i_host.xfer(9);
        for (int k = 0; k < 4; k++) chk("discByte", DISC[127 - 8 * ((14 + k) % 16) -: 8], i_host.rxBuf[5 + k]);
        report_and_stop();
    end
endmodule // tb

`default_nettype wire
